// file: hdl/hfa_pkg.sv
// hfa_pkg: constants for the half-flash converter host controller
// assumes a 125 MHz system clock
package hfa_pkg;
   localparam int    CLK_NS         = 8;
   localparam int    WAKE_NS        = 360;
   localparam int    ACQ_NS         = 160;
   localparam int    WR_PULSE_NS    = 250;
   localparam int    RD_GAP_NS      = 250;
   localparam int    ACC_NS         = 185;
   localparam int    CONV_RD_NS     = 700;
   localparam int    WAKE_CYC       = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int    ACQ_CYC        = (ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int    WR_PULSE_CYC   = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int    RD_GAP_CYC     = (RD_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int    ACC_CYC        = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int    CONV_RD_CYC    = (CONV_RD_NS + CLK_NS - 1) / CLK_NS;
   localparam int    CNT_W          = 8;
   // register offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_START  = 4'h1;
   localparam logic [3:0] OFS_STATUS = 4'h2;
   localparam logic [3:0] OFS_RESULT = 4'h3;
   // control fields
   localparam int    CTRL_MODE     = 0;
   localparam int    CTRL_SLEEPN   = 1;
   localparam int    CTRL_PIPE     = 2;
   localparam int    CTRL_CHAN_LO  = 4;
   localparam logic [7:0] CTRL_RESET = 8'h02;
   // status fields
   localparam int    ST_BUSY       = 0;
   localparam int    ST_DONE       = 1;
   localparam int    ST_AWAKE      = 2;
   localparam int    ST_RDY        = 3;
   localparam int    ST_END        = 4;

   typedef enum logic [2:0] {
      HFA_IDLE  = 3'b000,
      HFA_WAKE  = 3'b001,
      HFA_ACQ   = 3'b010,
      HFA_WRLO  = 3'b011,
      HFA_WAIT  = 3'b100,
      HFA_RDLO  = 3'b101,
      HFA_DONE  = 3'b110
   } hfa_state_t;
endpackage

// file: hdl/hfa_pins_if.sv
// hfa_pins_if: synchronised pin inputs between sync stage and controller
// assumes one clock domain
`timescale 1ns/10ps
interface hfa_pins_if;
   logic       endFlagN;
   logic       rdyLvl;
   logic [7:0] resultBus;
   modport src (output endFlagN, output rdyLvl, output resultBus);
   modport dst (input endFlagN, input rdyLvl, input resultBus);
endinterface

// file: hdl/hfa_sync.sv
// hfa_sync: three-stage synchronisers on converter pin inputs
// assumes asynchronous pins; change accepted when stages two and three agree
`timescale 1ns/10ps
module hfa_sync (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       endFlagNPin,
   input  wire logic       rdyPin,
   input  wire logic [7:0] dataPin,
   hfa_pins_if.src         pins
);
   logic [9:0] s1, s2, s3, q;
   logic [9:0] next_q;
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= 10'h3FF;
         s2 <= 10'h3FF;
         s3 <= 10'h3FF;
         q  <= 10'h3FF;
      end else begin
         s1 <= {rdyPin, endFlagNPin, dataPin};
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end
   assign pins.resultBus = q[7:0];
   assign pins.endFlagN  = q[8];
   assign pins.rdyLvl    = q[9];
endmodule // hfa_sync

// file: hdl/hfa_host.sv
// hfa_host: host controller driving a half-flash 8-bit converter
// assumes pins synchronised by hfa_sync; software port with 1-cycle reads
// Functional notes
// - mode pin picks read or write-read protocol
// - channel address binary, msb on top
// - wait 360ns after wake before converting
// - hold channel address for acquisition time
// - shared pin: write strobe or ready status
// - read mode: read starts, ready, end flag
// - write-read: write starts, end flag completes
// - tied strobes start next, read previous
// - address code n selects input n+1
`timescale 1ns/10ps
module hfa_host
   import hfa_pkg::*;
#(
   parameter int CHAN_W = 3
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [3:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [7:0]             regRdData,
   output logic                   csN,
   output logic                   rdN,
   output logic                   wrRdyOut,
   output logic                   wrRdyOe,
   input  wire logic              wrRdyIn,
   output logic                   modeSel,
   output logic [CHAN_W-1:0]      chanSel,
   output logic                   sleep_n,
   input  wire logic              endFlagNIn,
   input  wire logic [7:0]        resultIn
);
   ////////////////////////////////////////////////////////////////////////
   hfa_pins_if pins ();
   hfa_sync u_sync (
      .clk         (clk),
      .rst         (rst),
      .endFlagNPin (endFlagNIn),
      .rdyPin      (wrRdyIn),
      .dataPin     (resultIn),
      .pins        (pins)
   );

   ////////////////////////////////////////////////////////////////////////
   hfa_state_t       state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [7:0]       ctrl, next_ctrl;
   logic [7:0]       result, next_result;
   logic             done, next_done;
   logic             awake, next_awake;
   logic             wake;
   logic             startReq;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      return CNT_W'(n);
   endfunction

   assign startReq = regWr && regAddr == OFS_START;
   assign wake = ctrl[CTRL_SLEEPN] && !awake;

   always_comb begin
      next_state  = state;
      next_cnt    = (cnt != '0) ? cnt - 1'b1 : cnt;
      next_ctrl   = ctrl;
      next_result = result;
      next_done   = done;
      next_awake  = awake;
      if (regWr && regAddr == OFS_CTRL && state == HFA_IDLE) begin
         next_ctrl = regWrData;
      end
      if (regRd && regAddr == OFS_RESULT) begin
         next_done = 1'b0;
      end
      if (!ctrl[CTRL_SLEEPN]) begin
         next_awake = 1'b0;
      end
      case (state)
         HFA_IDLE: begin
            if (wake) begin
               next_state = HFA_WAKE;
               next_cnt   = cyc(WAKE_CYC);
            end else if (startReq && awake) begin
               next_state = HFA_ACQ;
               next_cnt   = cyc(ACQ_CYC);
            end
         end
         HFA_WAKE: begin
            if (cnt == '0) begin
               next_awake = 1'b1;
               next_state = HFA_IDLE;
            end
         end
         HFA_ACQ: begin
            if (cnt == '0) begin
               if (ctrl[CTRL_MODE]) begin
                  next_state = HFA_WRLO;
                  next_cnt   = cyc(WR_PULSE_CYC);
               end else begin
                  next_state = HFA_RDLO;
                  next_cnt   = cyc(CONV_RD_CYC + ACC_CYC);
               end
            end
         end
         HFA_WRLO: begin
            if (cnt == '0) begin
               if (ctrl[CTRL_PIPE]) begin
                  next_result = pins.resultBus;
                  next_done   = 1'b1;
                  next_state  = HFA_DONE;
                  next_cnt    = cyc(ACQ_CYC);
               end else begin
                  next_state = HFA_WAIT;
                  next_cnt   = cyc(RD_GAP_CYC);
               end
            end
         end
         HFA_WAIT: begin
            if (cnt == '0 && !pins.endFlagN) begin
               next_state = HFA_RDLO;
               next_cnt   = cyc(ACC_CYC);
            end
         end
         HFA_RDLO: begin
            // read mode ends on end flag and ready high
            if (cnt == '0 && !pins.endFlagN &&
                (ctrl[CTRL_MODE] || pins.rdyLvl)) begin
               next_result = pins.resultBus;
               next_done   = 1'b1;
               next_state  = HFA_DONE;
               next_cnt    = cyc(ACQ_CYC);
            end
         end
         HFA_DONE: begin
            if (cnt == '0) begin
               next_state = HFA_IDLE;
            end
         end
         default: next_state = HFA_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state  <= HFA_IDLE;
         cnt    <= '0;
         ctrl   <= CTRL_RESET;
         result <= 8'h00;
         done   <= 1'b0;
         awake  <= 1'b0;
      end else begin
         state  <= next_state;
         cnt    <= next_cnt;
         ctrl   <= next_ctrl;
         result <= next_result;
         done   <= next_done;
         awake  <= next_awake;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive, registered
   logic next_csN, next_rdN, next_wrN;
   logic inConv;
   assign inConv = state == HFA_WRLO || state == HFA_WAIT ||
                   state == HFA_RDLO;
   always_comb begin
      next_csN = !inConv;
      next_rdN = !(next_state == HFA_RDLO ||
                   (next_state == HFA_WRLO && ctrl[CTRL_PIPE]));
      next_wrN = next_state != HFA_WRLO;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         csN      <= 1'b1;
         rdN      <= 1'b1;
         wrRdyOut <= 1'b1;
      end else begin
         csN      <= next_csN && !(next_state inside {HFA_WRLO, HFA_WAIT,
                                                      HFA_RDLO});
         rdN      <= next_rdN;
         wrRdyOut <= next_wrN;
      end
   end
   assign wrRdyOe = ctrl[CTRL_MODE];
   assign modeSel = ctrl[CTRL_MODE];
   assign chanSel = ctrl[CTRL_CHAN_LO +: CHAN_W];
   assign sleep_n = ctrl[CTRL_SLEEPN];

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] next_rdData;
   always_comb begin
      case (regAddr)
         OFS_CTRL:   next_rdData = ctrl;
         OFS_STATUS: next_rdData = {3'h0, pins.endFlagN, pins.rdyLvl,
                                    awake, done, state != HFA_IDLE};
         OFS_RESULT: next_rdData = result;
         default:    next_rdData = 8'h00;
      endcase
      if (!regRd) begin
         next_rdData = 8'h00;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= next_rdData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_CS_WITH_STROBE: assert property (@(posedge clk) disable iff (rst)
      (!rdN || (wrRdyOe && !wrRdyOut)) |-> !csN)
      else $error("strobe without chip select");
   AST_WAKE_WAIT: assert property (@(posedge clk) disable iff (rst)
      (state == HFA_IDLE && wake) |=> !awake [*8])
      else $error("converted too soon after wake");
   AST_SLEEP_PIN: assert property (@(posedge clk) disable iff (rst)
      !sleep_n |=> !awake)
      else $error("awake while asleep");
   AST_WR_HIGH_READ: assert property (@(posedge clk) disable iff (rst)
      !modeSel |-> wrRdyOut && !wrRdyOe)
      else $error("write strobe or drive on ready pin in read mode");
   AST_ACQ_LEN: assert property (@(posedge clk) disable iff (rst)
      $rose(state == HFA_ACQ) |-> (state == HFA_ACQ) [*8])
      else $error("acquisition too short");
   AST_MODE_STABLE: assert property (@(posedge clk) disable iff (rst)
      state != HFA_IDLE |=> $stable(modeSel) && $stable(chanSel))
      else $error("mode or channel changed mid conversion");
   AST_DONE_CAUSE: assert property (@(posedge clk) disable iff (rst)
      $rose(done) |-> $past(state) inside {HFA_RDLO, HFA_WRLO})
      else $error("done without read");
   AST_WR_PULSE: assert property (@(posedge clk) disable iff (rst)
      $fell(wrRdyOut) |-> !wrRdyOut [*8])
      else $error("write pulse too short");
endmodule // hfa_host

// file: tb/hfa_dev_model.sv
// hfa_dev_model: behavioural half-flash converter seen from its pins
// assumes the host holds chip select low across each strobe
`timescale 1ns/10ps
module hfa_dev_model #(
   parameter int CONV_CYC = 80,
   parameter int INTL_CYC = 40
) (
   input  wire logic       clk,
   input  wire logic       csN,
   input  wire logic       rdN,
   input  wire logic       wrN,
   input  wire logic       modeLvl,
   input  wire logic [2:0] chanSel,
   input  wire logic       sleep_n,
   output logic            endFlagN,
   output logic            rdyOe,
   output logic [7:0]      data
);
   logic [7:0] outLatch, lastOut, code;
   logic       rdWas, wrWas, csWas, rdNWas;
   int         cnt;
   wire        modeHi = modeLvl === 1'b1;
   wire        rdAct = !csN && !rdN;
   wire        wrAct = !csN && !wrN && modeHi;
   function automatic logic [7:0] conv(input logic [2:0] ch);
      return (ch == 3'h7) ? 8'hFF : {1'b0, ch, 4'hA};
   endfunction
   // released bus shows the inverse of the last value
   assign data = rdAct ? outLatch : ~lastOut;
   initial begin
      {endFlagN, rdyOe, rdWas, wrWas, csWas, rdNWas} = 6'b100011;
      {outLatch, lastOut, code} = 24'h000000;
      cnt = 0;
   end
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      rdWas <= rdAct;
      wrWas <= wrAct;
      csWas <= csN;
      rdNWas <= rdN;
      if (rdAct)
         lastOut <= outLatch;
      if (cnt > 0)
         cnt <= cnt - 1;
      if ((rdN && !rdNWas) || (csN && !csWas))
         endFlagN <= 1'b1;
      if (!sleep_n) begin
         cnt <= 0;
         rdyOe <= 1'b0;
      end else if (!modeHi && rdAct && !rdWas) begin
         code <= conv(chanSel);
         cnt <= CONV_CYC;
         rdyOe <= 1'b1;
      end else if (wrAct && !wrWas) begin
         code <= conv(chanSel);
      end else if (!wrAct && wrWas) begin
         outLatch[7:4] <= code[7:4];
         cnt <= INTL_CYC;
      end else if (cnt == 1) begin
         outLatch <= {modeHi ? outLatch[7:4] : code[7:4], code[3:0]};
         endFlagN <= 1'b0;
         rdyOe <= 1'b0;
      end
   end
endmodule // hfa_dev_model

// file: tb/hfa_host_test.sv
// hfa_host_test: register-level bench for the converter host controller
// assumes the device model on the pins and a pulled-up ready line
`timescale 1ns/10ps
module hfa_host_test
   import hfa_pkg::*;
;
   logic       clk, rst, regWr, regRd, csN, rdN, wrRdyOut, wrRdyOe;
   logic       modeSel, sleep_n, endFlagN, rdyOe;
   logic [3:0] regAddr;
   logic [7:0] regWrData, regRdData, resultIn, rd;
   logic [2:0] chanSel;
   int         n_mismatch, cmp_count, cycles, t0;
   wire        wrRdyWire = wrRdyOe ? wrRdyOut : !rdyOe;

   hfa_host #(.CHAN_W(3)) dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .csN(csN), .rdN(rdN), .wrRdyOut(wrRdyOut),
      .wrRdyOe(wrRdyOe), .wrRdyIn(wrRdyWire), .modeSel(modeSel),
      .chanSel(chanSel), .sleep_n(sleep_n), .endFlagNIn(endFlagN),
      .resultIn(resultIn));
   hfa_dev_model dev_u (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrRdyWire),
      .modeLvl(modeSel), .chanSel(chanSel), .sleep_n(sleep_n),
      .endFlagN(endFlagN), .rdyOe(rdyOe), .data(resultIn));

   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] expCode(input logic [2:0] ch);
      return (ch == 3'h7) ? 8'hFF : {1'b0, ch, 4'hA};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic regRead(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic waitBit(input int b, input logic v);
      int i;
      for (i = 0; i < 400; i++) begin
         regRead(OFS_STATUS, rd);
         if (rd[b] === v)
            break;
      end
      if (i == 400)
         check(8'h00, 8'h01);
   endtask
   task automatic convert(input logic [7:0] ctl, input logic [7:0] exp);
      waitBit(ST_BUSY, 1'b0);
      regWrite(OFS_CTRL, ctl);
      regWrite(OFS_START, 8'h01);
      waitBit(ST_DONE, 1'b1);
      regRead(OFS_RESULT, rd);
      check(rd, exp);
      regRead(OFS_STATUS, rd);
      check({7'h00, rd[ST_DONE]}, 8'h00);
      check({5'h00, csN, rdN, wrRdyOut}, 8'h07);
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      {clk, rst, regWr, regRd, regAddr, regWrData} = 16'h4000;
      {n_mismatch, cmp_count, cycles} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      check({csN, rdN, wrRdyOe, sleep_n, modeSel, wrRdyOut, 2'h0},
            8'hD4);
      regRead(OFS_CTRL, rd);
      check(rd, CTRL_RESET);
      regRead(4'hF, rd);
      check(rd, 8'h00);
      waitBit(ST_AWAKE, 1'b1);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         convert({1'b0, c[2:0], 4'h2}, expCode(c[2:0]));
         check({5'h00, chanSel}, {5'h00, c[2:0]});
      end
      check({7'h00, wrRdyOe}, 8'h00);
      $display("test read mode done");
      convert(8'h33, expCode(3'h3));
      convert(8'h73, 8'hFF);
      check({6'h00, wrRdyOe, modeSel}, 8'h03);
      $display("test write-read done");
      convert(8'h57, 8'hFF);
      convert(8'h27, expCode(3'h5));
      $display("test pipelined done");
      waitBit(ST_BUSY, 1'b0);
      regWrite(OFS_CTRL, 8'h10);
      regWrite(OFS_START, 8'h01);
      check({7'h00, sleep_n}, 8'h00);
      regRead(OFS_STATUS, rd);
      check({7'h00, rd[ST_BUSY]}, 8'h00);
      t0 = cycles;
      regWrite(OFS_CTRL, 8'h12);
      waitBit(ST_AWAKE, 1'b1);
      check({7'h00, (cycles - t0 >= WAKE_CYC)}, 8'h01);
      convert(8'h12, expCode(3'h1));
      $display("test sleep done");
      print_verdict;
   end
endmodule // hfa_host_test
